// ===== include/pbu_pkg.sv
// Purpose: Constants for the upper port pin control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses
// Summary of operation
// - Direction 0 drives output latch value
// - Direction 1 reads sampled TTL input
// - Pull-up on digital inputs while disable bit clear
// - Pins 0-3 analog by default until config bits set; pins 4-7 always digital
// - Programming mode disables other functions on pins 6 and 7
// - Don't-care functions ignore the direction bit
// - Pin 6 programming clock, pin 7 data
// - Pins 4-7 are remappable pins 7-10
// - Parallel address lines own pins 4, 5
// - Unimplemented bits read as zero
// - Mismatch keeps setting the change flag
// - Flag clearable two cycles after port read
package pbu_pkg;
  localparam logic [7:0] OFS_PORT     = 8'h00;
  localparam logic [7:0] OFS_LAT      = 8'h04;
  localparam logic [7:0] OFS_DIR      = 8'h08;
  localparam logic [7:0] OFS_ICON     = 8'h0c;
  localparam logic [7:0] OFS_ICON2    = 8'h10;
  localparam logic [7:0] OFS_ICON3    = 8'h14;
  localparam logic [7:0] OFS_ANCFG    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_FUNC_SEL = 8'h24;
  // Field positions
  localparam int ICON_CHG_FLAG   = 0;
  localparam int ICON_CHG_EN     = 3;
  localparam int ICON2_CHG_PRIO  = 0;
  localparam int ICON2_PU_DIS    = 7;
  localparam int FSEL_PROG_EN    = 0;
  localparam int FSEL_PMA_EN     = 1;
  localparam int FSEL_CCP_EN_LSB = 4;
  // Implemented masks
  localparam logic [7:0] ANCFG_MASK = 8'h9f;
  localparam logic [7:0] ICON_MASK  = 8'hff;
  localparam logic [7:0] FSEL_MASK  = 8'hf3;
  // Reset values
  localparam logic [7:0] DIR_RST   = 8'hff;
  localparam logic [7:0] ICON2_RST = 8'hff;
  localparam logic [7:0] ANCFG_RST = 8'h00;
  // No upper pin is analog-capable; only low pins 0-3 are analog here
  localparam logic [7:0] ANALOG_PINS = 8'h0f;
  // Delay before the flag may be cleared after a port read
  localparam int CLR_HOLD_CYC = 1;
  localparam int IRQ_BITS     = 3;
  localparam int IRQ_CHANGE   = 0;
  localparam int IRQ_MISMATCH = 1;
  localparam int IRQ_PROG     = 2;
endpackage

// ===== rtl/pbu_port.sv
// Purpose: Port pin control for an 8-bit port, upper pins muxed except for remap_out
// Assumes: APB slave, single clock, peripherals on the same clock
// Notes:   Pad drive uses active-low output enables
`timescale 1ns/100ps
module pbu_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pad_in,
  output logic      [7:0]  pad_out,
  output logic      [7:0]  pad_oe_n,
  output logic      [7:0]  pad_pullup,
  output logic      [7:0]  pad_digital_en,
  output logic      [3:0]  remap_in,
  input  wire logic [3:0]  remap_out,
  input  wire logic [3:0]  capture_compare_out,
  output logic      [3:0]  capture_compare_in,
  input  wire logic [1:0]  parallel_addr_out,
  input  wire logic [1:0]  parallel_addr_oe,
  output logic      [1:0]  parallel_addr_in,
  input  wire logic        prog_mode,
  input  wire logic        prog_serial_data_out,
  input  wire logic        prog_serial_data_oe,
  output logic             prog_serial_clock,
  output logic             prog_serial_data_in,
  output logic             port_change_flag,
  output logic             port_change_irq_hi,
  output logic             irq
);
  logic [7:0] lat;
  logic [7:0] dir;
  logic [7:0] icon;
  logic [7:0] icon2;
  logic [7:0] icon3;
  logic [7:0] ancfg;
  logic [7:0] fsel;
  logic [pbu_pkg::IRQ_BITS-1:0] irq_stat;
  logic [pbu_pkg::IRQ_BITS-1:0] irq_mask;
  logic [7:0] pin_sync;
  logic [3:0] change_latch;
  logic [3:0] clr_wait;
  logic       mismatch;
  logic       prog_d;
  logic [7:0] digital_en;
  logic [7:0] next_out;
  logic [7:0] next_oe_n;
  logic [7:0] pin_view;
  logic       wr_acc;
  logic       rd_acc;
  logic       port_rd;
  logic       clr_ok;
  logic [31:0] next_rdata;

  pbu_sync #(
    .WIDTH (8)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign port_rd = psel && penable && (paddr == pbu_pkg::OFS_PORT);

  assign digital_en = ~pbu_pkg::ANALOG_PINS | ancfg;
  assign pin_view = pin_sync & digital_en;

  // Pin drive: latch by default, peripherals override in priority order
  always_comb begin
    next_out  = lat;
    next_oe_n = dir;
    for (int i = 4; i < 8; i++) begin
      if (fsel[pbu_pkg::FSEL_CCP_EN_LSB + i - 4] && !dir[i]) begin
        next_out[i] = capture_compare_out[i-4];
      end
    end
    if (fsel[pbu_pkg::FSEL_PMA_EN]) begin
      next_out[5]  = parallel_addr_out[0];
      next_oe_n[5] = ~parallel_addr_oe[0];
      next_out[4]  = parallel_addr_out[1];
      next_oe_n[4] = ~parallel_addr_oe[1];
    end
    if (prog_d) begin
      next_oe_n[6] = 1'b1;
      next_out[6]  = 1'b0;
      next_out[7]  = prog_serial_data_out;
      next_oe_n[7] = ~prog_serial_data_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_d <= 1'b0;
    end else begin
      prog_d <= prog_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out        <= '0;
      pad_oe_n       <= 8'hff;
      pad_pullup     <= '0;
      pad_digital_en <= '0;
    end else begin
      pad_out        <= next_out;
      pad_oe_n       <= next_oe_n;
      pad_pullup     <= icon2[pbu_pkg::ICON2_PU_DIS] ? 8'h00 : (next_oe_n & digital_en);
      pad_digital_en <= digital_en;
    end
  end

  // Peripheral input routing; blocked while programming owns pins 6 and 7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remap_in            <= '0;
      capture_compare_in  <= '0;
      parallel_addr_in    <= '0;
      prog_serial_clock   <= 1'b0;
      prog_serial_data_in <= 1'b0;
    end else begin
      for (int i = 4; i < 8; i++) begin
        remap_in[i-4]           <= dir[i] ? pin_sync[i] : 1'b0;
        capture_compare_in[i-4] <= (dir[i] && fsel[pbu_pkg::FSEL_CCP_EN_LSB + i - 4])
                                   ? pin_sync[i] : 1'b0;
      end
      if (prog_d) begin
        remap_in[3:2]           <= 2'b00;
        capture_compare_in[3:2] <= 2'b00;
      end
      parallel_addr_in    <= {pin_sync[4], pin_sync[5]};
      prog_serial_clock   <= prog_d ? pin_sync[6] : 1'b0;
      prog_serial_data_in <= prog_d ? pin_sync[7] : 1'b0;
    end
  end

  assign mismatch = |((pin_view[7:4] ^ change_latch) & dir[7:4]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_latch <= '0;
    end else if (port_rd) begin
      change_latch <= pin_view[7:4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_wait <= '0;
    end else if (port_rd) begin
      clr_wait <= 4'(pbu_pkg::CLR_HOLD_CYC);
    end else if (clr_wait != 4'h0) begin
      clr_wait <= clr_wait - 4'h1;
    end
  end
  assign clr_ok = (clr_wait == 4'h0) && !port_rd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat   <= '0;
      dir   <= pbu_pkg::DIR_RST;
      icon  <= '0;
      icon2 <= pbu_pkg::ICON2_RST;
      icon3 <= '0;
      ancfg <= pbu_pkg::ANCFG_RST;
      fsel  <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_acc) begin
        case (paddr)
          pbu_pkg::OFS_PORT:     lat      <= pwdata[7:0];
          pbu_pkg::OFS_LAT:      lat      <= pwdata[7:0];
          pbu_pkg::OFS_DIR:      dir      <= pwdata[7:0];
          pbu_pkg::OFS_ICON2:    icon2    <= pwdata[7:0];
          pbu_pkg::OFS_ICON3:    icon3    <= pwdata[7:0];
          pbu_pkg::OFS_ANCFG:    ancfg    <= pwdata[7:0] & pbu_pkg::ANCFG_MASK;
          pbu_pkg::OFS_FUNC_SEL: fsel     <= pwdata[7:0] & pbu_pkg::FSEL_MASK;
          pbu_pkg::OFS_IRQ_MASK: irq_mask <= pwdata[pbu_pkg::IRQ_BITS-1:0];
          default: ;
        endcase
      end
      if (wr_acc && paddr == pbu_pkg::OFS_ICON) begin
        icon[7:1] <= pwdata[7:1];
        icon[pbu_pkg::ICON_CHG_FLAG] <= mismatch |
          (pwdata[pbu_pkg::ICON_CHG_FLAG] | !clr_ok & icon[pbu_pkg::ICON_CHG_FLAG]);
      end else if (mismatch) begin
        icon[pbu_pkg::ICON_CHG_FLAG] <= 1'b1;
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      for (int b = 0; b < pbu_pkg::IRQ_BITS; b++) begin
        if (wr_acc && paddr == pbu_pkg::OFS_IRQ_STAT && pwdata[b]) begin
          irq_stat[b] <= 1'b0;
        end
      end
      if (mismatch && icon[pbu_pkg::ICON_CHG_EN]) irq_stat[pbu_pkg::IRQ_CHANGE] <= 1'b1;
      if (mismatch) irq_stat[pbu_pkg::IRQ_MISMATCH] <= 1'b1;
      if (prog_mode && !prog_d) irq_stat[pbu_pkg::IRQ_PROG] <= 1'b1;
    end
  end

  always_comb begin
    next_rdata = '0;
    case (paddr)
      pbu_pkg::OFS_PORT:     next_rdata[7:0] = pin_view;
      pbu_pkg::OFS_LAT:      next_rdata[7:0] = lat;
      pbu_pkg::OFS_DIR:      next_rdata[7:0] = dir;
      pbu_pkg::OFS_ICON:     next_rdata[7:0] = icon & pbu_pkg::ICON_MASK;
      pbu_pkg::OFS_ICON2:    next_rdata[7:0] = icon2;
      pbu_pkg::OFS_ICON3:    next_rdata[7:0] = icon3;
      pbu_pkg::OFS_ANCFG:    next_rdata[7:0] = ancfg;
      pbu_pkg::OFS_FUNC_SEL: next_rdata[7:0] = fsel;
      pbu_pkg::OFS_IRQ_STAT: next_rdata[pbu_pkg::IRQ_BITS-1:0] = irq_stat;
      pbu_pkg::OFS_IRQ_MASK: next_rdata[pbu_pkg::IRQ_BITS-1:0] = irq_mask;
      default:               next_rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_change_flag   <= 1'b0;
      port_change_irq_hi <= 1'b0;
      irq                <= 1'b0;
    end else begin
      port_change_flag   <= icon[pbu_pkg::ICON_CHG_FLAG];
      port_change_irq_hi <= icon[pbu_pkg::ICON_CHG_FLAG] & icon[pbu_pkg::ICON_CHG_EN]
                            & icon2[pbu_pkg::ICON2_CHG_PRIO];
      irq                <= |(irq_stat & irq_mask);
    end
  end
endmodule

// ===== rtl/pbu_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous pin inputs
// Notes:   Output changes once stages two and three agree
`timescale 1ns/100ps
module pbu_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_out[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule

// ===== tb/pbu_pins_model.sv
// Purpose: Board-side pin model
// Assumes: Bench chooses external drive per pin
// Notes:   Floating pins toggle every cycle
`timescale 1ns/100ps
module pbu_pins_model (
  input  wire logic       pclk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output logic      [7:0] pad_in
);
  logic [7:0] last = 8'h00;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_drv[i] ? ext_val[i] :
                  pad_pullup[i] ? 1'b1 : !last[i];
    end
  end
  always_ff @(posedge pclk) begin
    last <= pad_in;
  end
endmodule

// ===== tb/pbu_port_properties.sv
// Purpose: Port-level assertions for the upper port block
// Assumes: One clock, async active-low reset
// Notes:   Sees top-level ports only
`timescale 1ns/100ps
module pbu_port_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pad_oe_n,
  input wire logic [7:0]  pad_pullup,
  input wire logic        prog_mode,
  input wire logic        prog_serial_data_oe,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_slverr_low: assert property (pslverr == 1'b0)
    else $error("slave error raised");
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_unmapped_zero: assert property (pready && !pwrite && paddr > 8'h24 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_pullup_inputs: assert property ((pad_pullup & ~pad_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  a_prog_clk_in: assert property (prog_mode ##1 prog_mode ##1 prog_mode |-> pad_oe_n[6])
    else $error("programming clock pin driven");
  a_prog_data_dir: assert property (prog_mode ##1 prog_mode ##1 prog_mode |->
    pad_oe_n[7] == !$past(prog_serial_data_oe))
    else $error("programming data direction wrong");
  c_write: cover property (pready && pwrite);
  c_prog: cover property (prog_mode ##1 prog_mode);
  c_irq: cover property ($rose(irq));
endmodule
bind pbu_port pbu_port_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pad_oe_n, .pad_pullup, .prog_mode, .prog_serial_data_oe, .irq);

// ===== tb/pbu_port_tb_top.sv
// Purpose: Self-checking bench for the upper port block
// Assumes: Bench is APB master
// Notes:   Register model in an associative array
`timescale 1ns/100ps
module pbu_port_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, ext_val = 0, ext_drv = 8'hff, l, d;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, prog_mode = 0, pdo = 0, pdoe = 0;
  logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pullup, dig_en;
  logic [3:0]  remap_in, remap_out = 0, cc_out = 0;
  logic [1:0]  pa_out = 0, pa_oe = 0;
  logic        pclk_prog, flag, irq;
  logic [31:0] mdl [logic [7:0]];
  int          fails = 0, n_checks = 0, cyc = 0, seed = 55138;
  always #20 pclk = ~pclk;
  pbu_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pad_pullup, .pad_digital_en(dig_en),
    .remap_in, .remap_out, .capture_compare_out(cc_out), .capture_compare_in(),
    .parallel_addr_out(pa_out), .parallel_addr_oe(pa_oe), .parallel_addr_in(),
    .prog_mode, .prog_serial_data_out(pdo), .prog_serial_data_oe(pdoe),
    .prog_serial_clock(pclk_prog), .prog_serial_data_in(), .port_change_flag(flag),
    .port_change_irq_hi(), .irq);
  pbu_pins_model pins (.pclk, .pad_out, .pad_oe_n, .pad_pullup, .ext_val, .ext_drv,
    .pad_in);
  // Peripheral outputs wander; nothing owns the pins
  always @(posedge pclk) begin
    {remap_out, cc_out, pa_out} <= $random(seed);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      conclude;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    if (w && mdl.exists(a)) mdl[a] = dd & 32'hff;
  endtask
  task rdc(input logic [7:0] a);
    apb(0, a, 0);
    chk(r, mdl.exists(a) ? mdl[a] : 32'h0);
  endtask
  task conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    mdl[pbu_pkg::OFS_LAT] = 0;
    mdl[pbu_pkg::OFS_DIR] = 32'(pbu_pkg::DIR_RST);
    mdl[pbu_pkg::OFS_ICON2] = 32'(pbu_pkg::ICON2_RST);
    mdl[pbu_pkg::OFS_ANCFG] = 32'(pbu_pkg::ANCFG_RST);
    waitc(2);
    presetn <= 1;
    chk(dig_en[3:0], 4'h0);
    foreach (mdl[a]) rdc(a);
    rdc(8'h3c);
    for (int k = 0; k < 4; k++) begin
      l = $random(seed);
      d = $random(seed);
      ext_drv <= $random(seed);
      apb(1, pbu_pkg::OFS_LAT, {24'h0, l});
      apb(1, pbu_pkg::OFS_DIR, {24'h0, d});
      waitc(2);
      chk(pad_oe_n[7:4], d[7:4]);
      chk(pad_out[7:4] & ~d[7:4], l[7:4] & ~d[7:4]);
      rdc(pbu_pkg::OFS_LAT);
    end
    ext_drv <= 8'hff;
    ext_val <= $random(seed);
    apb(1, pbu_pkg::OFS_DIR, 32'hff);
    apb(1, pbu_pkg::OFS_ICON2, 32'h0);
    waitc(6);
    apb(0, pbu_pkg::OFS_PORT, 0);
    chk(r[7:4], ext_val[7:4]);
    chk(remap_in, ext_val[7:4]);
    chk(pad_pullup[7:4], 4'hf);
    waitc(2);
    apb(1, pbu_pkg::OFS_ICON, 32'h08);
    apb(1, pbu_pkg::OFS_IRQ_STAT, 32'h7);
    apb(1, pbu_pkg::OFS_IRQ_MASK, 32'h1);
    chk(irq, 1'b0);
    ext_val[5] <= !ext_val[5];
    waitc(8);
    chk({flag, irq}, 2'b11);
    apb(0, pbu_pkg::OFS_PORT, 0);
    waitc(2);
    apb(1, pbu_pkg::OFS_ICON, 32'h08);
    apb(1, pbu_pkg::OFS_IRQ_STAT, 32'h1);
    waitc(2);
    chk({flag, irq}, 2'b00);
    prog_mode <= 1;
    pdoe <= 1;
    pdo <= 1;
    waitc(6);
    chk(pad_oe_n[7:6], 2'b01);
    chk(pad_out[7], 1'b1);
    chk(pclk_prog, ext_val[6]);
    conclude;
  end
endmodule
